// ===== core/oscsd_pkg.sv
package oscsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices and byte addresses (byte address = index * 4)
  localparam logic [23:0] OSCSD_CTRL_IDX = 24'hFFE0A0;
  localparam logic [23:0] OSCSD_DIV_IDX = 24'hFFE0A1;
  localparam logic [23:0] OSCSD_STAT_IDX = 24'hFFE0A2;
  localparam logic [23:0] OSCSD_MASK_IDX = 24'hFFE0A3;
  localparam logic [31:0] OSCSD_CTRL_ADDR = {6'h00, OSCSD_CTRL_IDX, 2'h0};
  localparam logic [31:0] OSCSD_DIV_ADDR = {6'h00, OSCSD_DIV_IDX, 2'h0};
  localparam logic [31:0] OSCSD_STAT_ADDR = {6'h00, OSCSD_STAT_IDX, 2'h0};
  localparam logic [31:0] OSCSD_MASK_ADDR = {6'h00, OSCSD_MASK_IDX, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // unlock keys
  localparam logic [7:0] OSCSD_KEY_FIRST = 8'hE7;
  localparam logic [7:0] OSCSD_KEY_SECOND = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int OSCSD_PREC_BIT = 7;
  localparam int OSCSD_XTAL_BIT = 6;
  localparam int OSCSD_WDOSC_BIT = 5;
  localparam int OSCSD_PFD_BIT = 4;
  localparam int OSCSD_WFD_BIT = 3;
  localparam int OSCSD_FLP_BIT = 2;
  localparam int OSCSD_SEL_LSB = 0;
  localparam logic [7:0] OSCSD_CTRL_RESET = 8'hA0;
  localparam logic [1:0] OSCSD_SEL_PREC = 2'h0;
  localparam logic [1:0] OSCSD_SEL_XTAL = 2'h1;
  localparam logic [1:0] OSCSD_SEL_RSVD = 2'h2;
  localparam logic [1:0] OSCSD_SEL_WDOG = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // divide register reset values
  localparam logic [7:0] OSCSD_DIV_RESET = 8'h00;
  localparam logic [7:0] OSCSD_DIV_RESET_LP = 8'h08;
  localparam logic [7:0] OSCSD_DIV_OFF = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // status register bits (w1c on bits 1:0, rest read only)
  localparam int OSCSD_ST_PFAIL = 0;
  localparam int OSCSD_ST_WFAIL = 1;
  localparam int OSCSD_ST_FORCED = 2;
  localparam int OSCSD_ST_WDEAD = 3;
  localparam int OSCSD_ST_OPEN = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int OSCSD_WDT_FAIL_CYCLES = 8000;
  localparam logic [1:0] OSCSD_INIT_LOAD = 2'h2;
  localparam logic [1:0] OSCSD_INIT_DONE = 2'h3;

  // unlock state, one-hot
  typedef enum logic [2:0] {
    oscsd_locked = 3'h1,
    oscsd_key1 = 3'h2,
    oscsd_open = 3'h4
  } oscsd_lock_t;

endpackage

// ===== core/oscsd_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two flop synchroniser for asynchronous levels
module oscsd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("oscsd_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage

  // both stages clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // oscsd_sync
`default_nettype wire

// ===== core/oscsd_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// oscillator select and divide control with apb register access
module oscsd_top #(
  parameter int WDT_FAIL_CYCLES = oscsd_pkg::OSCSD_WDT_FAIL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power_option_bit,
  input wire logic primary_osc_fail,
  input wire logic watchdog_osc_clk,
  input wire logic flash_read_req,
  output logic precision_osc_on,
  output logic crystal_osc_on,
  output logic watchdog_osc_on,
  output logic [1:0] system_clock_source,
  output logic [7:0] clock_divide_value,
  output logic flash_low_power_on,
  output logic flash_powered,
  output logic system_exception,
  output logic irq
);

  if (WDT_FAIL_CYCLES < 2) begin : g_bad_wdt
    $error("oscsd_top watchdog failure window too short");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] oscillator_control_reg_q; // control register
  logic [7:0] clock_divide_reg_q; // divide register
  logic [1:0] stat_q; // sticky failure events
  logic [1:0] mask_q; // interrupt mask
  logic forced_q; // watchdog forced onto system clock
  logic wdog_dead_q; // watchdog failed, primary detect lost
  logic [1:0] init_cnt_q; // post reset option capture
  logic [31:0] prdata_q; // read data, loaded in setup
  logic pslverr_q; // error flag, loaded in setup
  logic exc_q; // exception pulse
  logic wedge_q; // delayed synced watchdog clock
  logic pfail_q; // delayed synced primary fail
  oscsd_pkg::oscsd_lock_t lock_q; // unlock sequence state
  logic opt_s; // synced option bit
  logic pfail_s; // synced primary failure level
  logic wclk_s; // synced watchdog clock
  logic wdt_fail; // watchdog failure pulse
  logic init_busy; // still capturing the option bit
  logic setup_ph; // apb setup cycle
  logic wr_acc; // apb write taking effect
  logic hit_ctrl;
  logic hit_div;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;
  logic wr_ctrl; // any write at control address
  logic wr_div; // any write at divide address
  logic ctrl_take; // control value accepted
  logic div_take; // divide value accepted
  logic pfail_evt; // primary failure detected
  logic wdt_edge; // watchdog clock rising edge
  logic [1:0] sel_wr; // select field after write filter

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: option, primary fail, watchdog clock
  oscsd_sync #(
    .WIDTH(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({low_power_option_bit, primary_osc_fail, watchdog_osc_clk}),
    .sync_out({opt_s, pfail_s, wclk_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // option capture after reset release
  // the option pin cannot be loaded by the async reset itself, so the
  // defaults are taken from the synced level once it has settled
  assign init_busy = init_cnt_q != oscsd_pkg::OSCSD_INIT_DONE;

  // counts up to done and stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_q <= '0;
    end else if (init_busy) begin
      init_cnt_q <= init_cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup_ph = psel && !penable;
  assign pready = !init_busy; // stall until defaults loaded
  assign wr_acc = psel && penable && pwrite && pready && pstrb[0];
  assign hit_ctrl = paddr == oscsd_pkg::OSCSD_CTRL_ADDR;
  assign hit_div = paddr == oscsd_pkg::OSCSD_DIV_ADDR;
  assign hit_stat = paddr == oscsd_pkg::OSCSD_STAT_ADDR;
  assign hit_mask = paddr == oscsd_pkg::OSCSD_MASK_ADDR;
  assign hit_any = hit_ctrl || hit_div || hit_stat || hit_mask;
  assign wr_ctrl = wr_acc && hit_ctrl;
  assign wr_div = wr_acc && hit_div;
  assign ctrl_take = wr_ctrl && lock_q == oscsd_pkg::oscsd_open;
  assign div_take = wr_div && lock_q == oscsd_pkg::oscsd_open;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence; both protected registers share it
  // non key writes and reads elsewhere leave a half sequence standing,
  // so software may touch other registers between the two keys
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= oscsd_pkg::oscsd_locked;
    end else begin
      case (lock_q)
        oscsd_pkg::oscsd_locked: begin
          if (wr_ctrl && pwdata[7:0] == oscsd_pkg::OSCSD_KEY_FIRST) begin
            lock_q <= oscsd_pkg::oscsd_key1;
          end
        end
        oscsd_pkg::oscsd_key1: begin
          if (wr_ctrl) begin
            if (pwdata[7:0] == oscsd_pkg::OSCSD_KEY_SECOND) begin
              lock_q <= oscsd_pkg::oscsd_open;
            end else if (pwdata[7:0] == oscsd_pkg::OSCSD_KEY_FIRST) begin
              lock_q <= oscsd_pkg::oscsd_key1; // repeated first key restarts
            end else begin
              lock_q <= oscsd_pkg::oscsd_locked;
            end
          end
        end
        oscsd_pkg::oscsd_open: begin
          if (wr_ctrl || wr_div) begin
            lock_q <= oscsd_pkg::oscsd_locked;
          end
        end
        default: begin
          lock_q <= oscsd_pkg::oscsd_locked;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // failure event detection
  // watchdog edge from the second sync stage and a local delay flop
  assign wdt_edge = wclk_s && !wedge_q;
  // primary failure counts only on its rising edge, only while enabled,
  // and not after the watchdog died (no time base left to judge by)
  assign pfail_evt = pfail_s && !pfail_q && !wdog_dead_q &&
                     oscillator_control_reg_q[oscsd_pkg::OSCSD_PFD_BIT];

  // edge detect delay flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wedge_q <= 1'b0;
      pfail_q <= 1'b0;
    end else begin
      wedge_q <= wclk_s;
      pfail_q <= pfail_s;
    end
  end

  // watchdog clock supervision
  oscsd_wdt_mon #(
    .FAIL_CYCLES(WDT_FAIL_CYCLES)
  ) u_wdt_mon (
    .pclk(pclk),
    .presetn(presetn),
    .enable(oscillator_control_reg_q[oscsd_pkg::OSCSD_WFD_BIT] && !init_busy),
    .wdt_edge(wdt_edge),
    .fail_pulse(wdt_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register
  // reserved select code keeps the previous source rather than stopping
  // the clock on an undefined path
  assign sel_wr = (pwdata[1:0] == oscsd_pkg::OSCSD_SEL_RSVD) ?
                  oscillator_control_reg_q[1:0] : pwdata[1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_control_reg_q <= oscsd_pkg::OSCSD_CTRL_RESET;
    end else if (init_cnt_q == oscsd_pkg::OSCSD_INIT_LOAD) begin
      oscillator_control_reg_q[oscsd_pkg::OSCSD_FLP_BIT] <= !opt_s;
    end else begin
      if (ctrl_take) begin
        oscillator_control_reg_q <= {pwdata[7:2], sel_wr};
      end
      // hardware clear beats a same cycle software write
      if (pfail_evt) begin
        oscillator_control_reg_q[oscsd_pkg::OSCSD_PFD_BIT] <= 1'b0;
      end
      if (wdt_fail) begin
        oscillator_control_reg_q[oscsd_pkg::OSCSD_WFD_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divide_reg_q <= oscsd_pkg::OSCSD_DIV_RESET;
    end else if (init_cnt_q == oscsd_pkg::OSCSD_INIT_LOAD) begin
      clock_divide_reg_q <= opt_s ? oscsd_pkg::OSCSD_DIV_RESET :
                            oscsd_pkg::OSCSD_DIV_RESET_LP;
    end else if (div_take) begin
      clock_divide_reg_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // failure recovery state
  // forced switch-over holds until software writes a new selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_q <= 1'b0;
    end else if (pfail_evt && oscillator_control_reg_q[1:0] !=
                 oscsd_pkg::OSCSD_SEL_WDOG) begin
      forced_q <= 1'b1;
    end else if (ctrl_take) begin
      forced_q <= 1'b0;
    end
  end

  // watchdog death is kept until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_dead_q <= 1'b0;
    end else if (wdt_fail) begin
      wdog_dead_q <= 1'b1;
    end
  end

  // one cycle system exception per failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= 1'b0;
    end else begin
      exc_q <= pfail_evt || wdt_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_acc && hit_stat && pwdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (pfail_evt) begin
        stat_q[oscsd_pkg::OSCSD_ST_PFAIL] <= 1'b1;
      end
      if (wdt_fail) begin
        stat_q[oscsd_pkg::OSCSD_ST_WFAIL] <= 1'b1;
      end
    end
  end

  // interrupt mask, plain read write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_acc && hit_mask) begin
      mask_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and error, captured in the setup cycle
  // capture in setup keeps prdata a flop while pready stays combinational
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      pslverr_q <= !hit_any;
      prdata_q <= '0;
      if (hit_ctrl) begin
        prdata_q <= {24'h000000, oscillator_control_reg_q};
      end else if (hit_div) begin
        prdata_q <= {24'h000000, clock_divide_reg_q};
      end else if (hit_stat) begin
        prdata_q <= {27'h0000000, lock_q == oscsd_pkg::oscsd_open,
                     wdog_dead_q,
                     forced_q, stat_q};
      end else if (hit_mask) begin
        prdata_q <= {30'h0000000, mask_q};
      end
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the clock generator and flash
  assign precision_osc_on = oscillator_control_reg_q[oscsd_pkg::OSCSD_PREC_BIT];
  assign crystal_osc_on = oscillator_control_reg_q[oscsd_pkg::OSCSD_XTAL_BIT];
  assign watchdog_osc_on =
    oscillator_control_reg_q[oscsd_pkg::OSCSD_WDOSC_BIT] || forced_q;
  assign system_clock_source = forced_q ? oscsd_pkg::OSCSD_SEL_WDOG :
                               oscillator_control_reg_q[1:0];
  assign clock_divide_value = clock_divide_reg_q;
  assign flash_low_power_on = oscillator_control_reg_q[oscsd_pkg::OSCSD_FLP_BIT];
  // combinational so a read request powers the flash in the same cycle
  assign flash_powered = !flash_low_power_on || flash_read_req;
  assign system_exception = exc_q;
  assign irq = |(stat_q & mask_q);

endmodule // oscsd_top
`default_nettype wire

// ===== core/oscsd_wdt_mon.sv
`timescale 1ns/10ps
`default_nettype none
// counts system cycles between watchdog clock edges
module oscsd_wdt_mon #(
  parameter int FAIL_CYCLES = oscsd_pkg::OSCSD_WDT_FAIL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic wdt_edge,
  output logic fail_pulse
);

  localparam int CW = $clog2(FAIL_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FAIL_CYCLES - 1);

  if (FAIL_CYCLES < 2) begin : g_bad_count
    $error("oscsd_wdt_mon needs at least two cycles");
  end

  logic [CW-1:0] cnt_q; // cycles since last watchdog edge

  // restart on every edge or while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!enable || wdt_edge || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // failure on the last edgeless cycle of the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_pulse <= 1'b0;
    end else begin
      fail_pulse <= enable && !wdt_edge && cnt_q == LAST;
    end
  end

endmodule // oscsd_wdt_mon
`default_nettype wire

// ===== dv/oscillator_select_and_divide_tb.sv
`timescale 1ns/10ps
`default_nettype none
// directed checks of locking, reset values and failure handling
module oscillator_select_and_divide_tb;
  localparam int FAIL_N = 16; // short watchdog window keeps the run brief
  localparam logic [31:0] CTRL = oscsd_pkg::OSCSD_CTRL_ADDR;
  localparam logic [31:0] DIV = oscsd_pkg::OSCSD_DIV_ADDR;
  localparam logic [31:0] STAT = oscsd_pkg::OSCSD_STAT_ADDR;
  localparam logic [31:0] MASK = oscsd_pkg::OSCSD_MASK_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic low_power_option_bit, primary_osc_fail, watchdog_osc_clk;
  logic flash_read_req, precision_osc_on, crystal_osc_on, watchdog_osc_on;
  logic flash_low_power_on, flash_powered, system_exception, err, wd_run;
  logic [1:0] system_clock_source;
  logic [7:0] clock_divide_value;
  int error_cnt, comparisons, cyc, exc_cnt, n;
  oscsd_top #(.WDT_FAIL_CYCLES(FAIL_N)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_option_bit(low_power_option_bit),
    .primary_osc_fail(primary_osc_fail), .watchdog_osc_clk(watchdog_osc_clk),
    .flash_read_req(flash_read_req), .precision_osc_on(precision_osc_on),
    .crystal_osc_on(crystal_osc_on), .watchdog_osc_on(watchdog_osc_on),
    .system_clock_source(system_clock_source),
    .clock_divide_value(clock_divide_value),
    .flash_low_power_on(flash_low_power_on), .flash_powered(flash_powered),
    .system_exception(system_exception), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // timeout, exception counting and the watchdog clock source
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (system_exception === 1'b1) exc_cnt <= exc_cnt + 1;
    if (wd_run) watchdog_osc_clk <= ~watchdog_osc_clk;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: expected %h got %h", $time, exp, got);
      error_cnt++;
    end
  endtask
  // one apb transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk); // outputs settle before the caller looks
  endtask
  task automatic unlock;
    apb(1'b1, CTRL, oscsd_pkg::OSCSD_KEY_FIRST);
    apb(1'b1, CTRL, oscsd_pkg::OSCSD_KEY_SECOND);
  endtask
  // reset with a given option level, then check the control and divide reset values
  task automatic t_reset(input logic opt);
    @(posedge pclk);
    presetn <= 1'b0;
    low_power_option_bit <= opt;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // read data is captured in setup, so start after option capture
    while (pready !== 1'b1) @(posedge pclk);
    apb(1'b0, CTRL, 8'h00);
    chk(opt ? 32'hA0 : 32'hA4, rd);
    apb(1'b0, DIV, 8'h00);
    chk(opt ? 32'h00 : 32'h08, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // locked writes, wrong key order, cancelled unlock, unmapped address
  task automatic t_lock;
    apb(1'b1, CTRL, 8'h41);
    apb(1'b1, DIV, 8'h33);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'hE7);
    apb(1'b1, CTRL, 8'h33);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h41);
    apb(1'b0, CTRL, 8'h00);
    chk(32'hA0, rd);
    apb(1'b0, DIV, 8'h00);
    chk(32'h00, rd);
    apb(1'b0, 32'h00000000, 8'h00);
    chk({31'h0, err}, 32'h1);
  endtask
  // unlock with a foreign access between keys, one write, then relock
  task automatic t_unlock_ctrl;
    apb(1'b1, CTRL, oscsd_pkg::OSCSD_KEY_FIRST);
    apb(1'b0, DIV, 8'h00);
    apb(1'b1, CTRL, oscsd_pkg::OSCSD_KEY_SECOND);
    apb(1'b1, CTRL, 8'hE1);
    chk(32'({crystal_osc_on, system_clock_source}), 32'h5);
    apb(1'b1, CTRL, 8'hA0);
    apb(1'b0, CTRL, 8'h00);
    chk(32'hE1, rd);
  endtask
  // divide register shares the keys and relocks after one write
  task automatic t_div;
    unlock();
    apb(1'b1, DIV, 8'hFF);
    apb(1'b1, DIV, 8'h00);
    chk(32'hFF, 32'(clock_divide_value));
    unlock();
    apb(1'b1, DIV, 8'h00);
    chk(32'h00, 32'(clock_divide_value));
  endtask
  // every select code; the reserved code keeps the last select
  task automatic t_sel;
    logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
    for (int i = 0; i < 4; i++) begin
      unlock();
      apb(1'b1, CTRL, {6'b111000, codes[i]});
      chk(32'(exp[i]), 32'(system_clock_source));
    end
  endtask
  // primary failure: exception, forced watchdog, sticky status and irq
  task automatic t_pfail;
    unlock();
    apb(1'b1, CTRL, 8'hB0);
    apb(1'b1, MASK, 8'h01);
    n = exc_cnt;
    @(posedge pclk);
    primary_osc_fail <= 1'b1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk(32'(n + 1), 32'(exc_cnt));
    chk(32'({system_clock_source, irq}), 32'h7);
    apb(1'b0, CTRL, 8'h00);
    chk(32'h0, {27'h0, rd[4], 4'h0});
    apb(1'b0, STAT, 8'h00);
    chk(32'h5, {29'h0, rd[2:0]});
    apb(1'b1, MASK, 8'h00);
    chk(32'h0, 32'(irq));
    apb(1'b1, STAT, 8'h01);
    apb(1'b0, STAT, 8'h00);
    chk(32'h0, {31'h0, rd[0]});
    @(posedge pclk);
    primary_osc_fail <= 1'b0;
    unlock();
    apb(1'b1, CTRL, 8'hA0);
    chk(32'h0, 32'(system_clock_source));
  endtask
  // watchdog failure only after the full edgeless window
  task automatic t_wfail;
    wd_run <= 1'b1;
    unlock();
    apb(1'b1, CTRL, 8'hA8);
    repeat (40) @(posedge pclk);
    n = exc_cnt;
    wd_run <= 1'b0;
    repeat (FAIL_N - 8) @(posedge pclk);
    apb(1'b0, CTRL, 8'h00);
    chk(32'h8, {28'h0, rd[3], 3'h0});
    repeat (20) @(posedge pclk);
    apb(1'b0, CTRL, 8'h00);
    chk(32'h0, {28'h0, rd[3], 3'h0});
    apb(1'b0, STAT, 8'h00);
    chk(32'hA, {28'h0, rd[3:0] & 4'hA});
    chk(32'(n + 1), 32'(exc_cnt));
  endtask
  // reset after a full unlock relocks; flash supply follows low power and reads
  task automatic t_relock;
    unlock();
    t_reset(1'b0);
    apb(1'b1, CTRL, 8'hE1);
    apb(1'b0, CTRL, 8'h00);
    chk(32'hA4, rd);
    @(posedge pclk);
    flash_read_req <= 1'b0;
    @(negedge pclk);
    chk(32'h0, 32'(flash_powered));
    @(posedge pclk);
    flash_read_req <= 1'b1;
    @(negedge pclk);
    chk(32'h1, 32'(flash_powered));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, primary_osc_fail} = 5'h00;
    {watchdog_osc_clk, flash_read_req, wd_run} = 3'h0;
    low_power_option_bit = 1'b1;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    {error_cnt, comparisons, cyc, exc_cnt, n} = '0;
    t_reset(1'b1);
    t_lock();
    t_unlock_ctrl();
    t_div();
    t_sel();
    t_pfail();
    t_wfail();
    t_relock();
    print_verdict();
  end
endmodule // oscillator_select_and_divide_tb
`default_nettype wire

// ===== dv/oscsd_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// passive pin-level checks for the oscillator control block
module oscsd_top_monitor #(
  parameter int WDT_FAIL_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic low_power_option_bit,
  input wire logic primary_osc_fail,
  input wire logic flash_read_req,
  input wire logic precision_osc_on,
  input wire logic crystal_osc_on,
  input wire logic watchdog_osc_on,
  input wire logic [1:0] system_clock_source,
  input wire logic [7:0] clock_divide_value,
  input wire logic flash_low_power_on,
  input wire logic flash_powered,
  input wire logic system_exception
);
  // one clock domain, async reset masks every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // an accepted apb write, and one each for the control and divide addresses
  wire logic acc_wr = psel && penable && pwrite && pready;
  wire logic ctrl_wr = acc_wr && (paddr == oscsd_pkg::OSCSD_CTRL_ADDR);
  wire logic div_wr = acc_wr && (paddr == oscsd_pkg::OSCSD_DIV_ADDR);
  ////////////////////////////////////////////////////////////////////////////
  property p_flash_pwr;
    flash_powered == (!flash_low_power_on || flash_read_req);
  endproperty
  a_flash_pwr: assert property (p_flash_pwr)
    else $error("flash supply level wrong");
  property p_rst_vals;
    $rose(presetn) |-> precision_osc_on && !crystal_osc_on &&
      watchdog_osc_on && (system_clock_source == 2'h0);
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("oscillator enables wrong after reset");
  // option load lands on the third edge after release
  property p_opt_load;
    $rose(presetn) |-> ##3 (flash_low_power_on == !low_power_option_bit) &&
      (clock_divide_value == (low_power_option_bit ? 8'h00 : 8'h08));
  endproperty
  a_opt_load: assert property (p_opt_load)
    else $error("option dependent reset values wrong");
  property p_init_ready;
    $rose(presetn) |-> !pready [*3] ##1 pready;
  endproperty
  a_init_ready: assert property (p_init_ready)
    else $error("bus ready timing after reset wrong");
  property p_ready_stays;
    pready |=> pready;
  endproperty
  a_ready_stays: assert property (p_ready_stays)
    else $error("bus ready dropped outside reset");
  property p_no_rsvd;
    system_clock_source != 2'h2;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd)
    else $error("reserved clock select on output");
  // once pready is up, precision and crystal enables and flash low power move only on a write to the control address
  property p_ctrl_hold;
    $past(pready) && $changed({precision_osc_on, crystal_osc_on,
      flash_low_power_on}) |-> $past(ctrl_wr);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control outputs moved without a write");
  property p_div_hold;
    $past(pready) && $changed(clock_divide_value) |-> $past(div_wr);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divide value moved without a write");
  property p_exc_pulse;
    system_exception |=> !system_exception;
  endproperty
  a_exc_pulse: assert property (p_exc_pulse)
    else $error("exception longer than one cycle");
  property p_forced;
    $rose(primary_osc_fail) ##[2:6] system_exception |->
      (system_clock_source == 2'h3) && watchdog_osc_on;
  endproperty
  a_forced: assert property (p_forced)
    else $error("failure did not force watchdog clock");
endmodule // oscsd_top_monitor
bind oscsd_top oscsd_top_monitor #(.WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .low_power_option_bit(low_power_option_bit),
  .primary_osc_fail(primary_osc_fail), .flash_read_req(flash_read_req),
  .precision_osc_on(precision_osc_on), .crystal_osc_on(crystal_osc_on),
  .watchdog_osc_on(watchdog_osc_on),
  .system_clock_source(system_clock_source),
  .clock_divide_value(clock_divide_value),
  .flash_low_power_on(flash_low_power_on), .flash_powered(flash_powered),
  .system_exception(system_exception));
`default_nettype wire
